// ### cbseq_pkg.sv
// Function
// - every cycle starts in address state, then data
// - no ack, no next-address: repeat data state
// - after ack: hold, new address, or idle
// - strobe asserted on every new address issued
// - next-address sampled each phase one until ack
// - one active next-address sample is enough
// - early address from next state if pending
// - nothing pending: data idle next, then pipe
// - address stable at least two processor clocks
// - pipelining reaches only one cycle ahead
// - pipelined cycle is addr pipe then data pipe
// - from idle or hold, start non-pipelined
// - only a data pipe ending gives pipelining
// - transition cycle: addr, data, data pipe waits
// - pipelined cycle starts right after the ack
// - prefetch stays pending until queue full
// - interrupt runs two acknowledged ack cycles
// - first ack cycle byte address 4, second 0
// - lock held across both ack cycles
// - exactly four idle states between ack cycles
// - data floats; vector latched on second ack
// - a bus state is two clock periods
// - ack sampled at end of data states
// - hold only granted when lock inactive
`default_nettype none
package cbseq_pkg;
  // ****************************************
  // bus states and cycle kinds
  // ****************************************
  typedef enum logic [2:0] {
    state_idle = 3'h0,
    state_addr = 3'h1,
    state_data = 3'h3,
    state_data_pipe = 3'h2,
    state_addr_pipe = 3'h6,
    state_data_idle_next = 3'h7,
    state_hold_ack = 3'h4
  } cbseq_state_t;
  typedef enum logic [2:0] {
    kind_fetch = 3'h0,
    kind_read = 3'h1,
    kind_write = 3'h3,
    kind_ack1 = 3'h2,
    kind_ack2 = 3'h6
  } cbseq_kind_t;
  typedef enum logic [1:0] {
    ia_none = 2'h0,
    ia_first = 2'h1,
    ia_gap = 2'h3,
    ia_second = 2'h2
  } cbseq_ia_t;
  // ****************************************
  // addresses, resets and timing
  // ****************************************
  localparam logic [22:0] ACK1_WORD_ADDR = 23'h000002;
  localparam logic [22:0] ACK2_WORD_ADDR = 23'h000000;
  localparam logic [1:0] ACK_BE_N = 2'h2;
  localparam logic [1:0] FETCH_BE_N = 2'h0;
  localparam logic [22:0] FETCH_RST_ADDR = 23'h000000;
  localparam logic [2:0] ACK_GAP_STATES = 3'h4;
  localparam logic [19:0] SYNC_RST = 20'hc0000;
  localparam logic PHASE_ONE = 1'b0;
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int BUS_STATE_CLKS = 2;
  localparam int ADDR_STABLE_CLKS = 2 * BUS_STATE_CLKS;
endpackage : cbseq_pkg
`default_nettype wire

// ### cbseq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cbseq_if;
  logic ph1_end;
  logic st_end;
  logic capture;
  logic [7:0] low_byte;
  logic [7:0] vector;
  logic vector_valid;
  modport tick (output ph1_end, output st_end);
  modport vec (input capture, input low_byte, output vector, output vector_valid);
endinterface : cbseq_if
`default_nettype wire

// ### cbseq_phase.sv
`timescale 1ns/10ps
`default_nettype none
module cbseq_phase import cbseq_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // bus state timing
  cbseq_if.tick tick
);
  logic phase_ff;

  // two clock periods per bus state
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_ff <= PHASE_ONE;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  assign tick.ph1_end = (phase_ff == PHASE_ONE);
  assign tick.st_end = (phase_ff != PHASE_ONE);
endmodule : cbseq_phase
`default_nettype wire

// ### cbseq_vector.sv
`timescale 1ns/10ps
`default_nettype none
module cbseq_vector import cbseq_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // capture port
  cbseq_if.vec vec
);
  logic [7:0] vector_ff;
  logic valid_ff;

  // only the low byte carries the vector
  always_ff @(posedge clock) begin
    if (srst) begin
      vector_ff <= 8'h00;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= vec.capture;
      if (vec.capture) begin
        vector_ff <= vec.low_byte;
      end
    end
  end

  assign vec.vector = vector_ff;
  assign vec.vector_valid = valid_ff;
endmodule : cbseq_vector
`default_nettype wire

// ### cbseq_top.sv
`timescale 1ns/10ps
`default_nettype none
module cbseq_top import cbseq_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // bus handshake pins
  input wire logic cycle_ack_n,
  input wire logic next_address_req_n,
  input wire logic bus_hold_req,
  input wire logic irq_request,
  input wire logic [15:0] data_in,
  // core request side
  input wire logic int_enable,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [22:0] req_addr,
  input wire logic [1:0] req_be_n,
  input wire logic [15:0] req_wdata,
  input wire logic queue_full,
  // bus outputs
  output logic address_strobe_n,
  output logic [20:0] address_hi,
  output logic addr_bit2,
  output logic addr_bit1,
  output logic high_byte_en_n,
  output logic low_byte_en_n,
  output logic write_read,
  output logic int_ack_cycle,
  output logic bus_lock_n,
  output logic bus_hold_grant,
  output logic [15:0] data_out,
  output logic data_oe,
  // core results
  output logic req_taken,
  output logic cycle_done,
  output logic [15:0] rd_data,
  output logic [7:0] irq_vector,
  output logic vector_valid,
  output logic [2:0] bus_state
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [22:0] issue_addr(cbseq_kind_t k, logic [22:0] ra, logic [22:0] pa);
    unique case (k)
      kind_ack1: issue_addr = ACK1_WORD_ADDR;
      kind_ack2: issue_addr = ACK2_WORD_ADDR;
      kind_fetch: issue_addr = pa;
      default: issue_addr = ra;
    endcase
  endfunction : issue_addr

  function automatic logic [1:0] issue_be(cbseq_kind_t k, logic [1:0] rb);
    unique case (k)
      kind_ack1, kind_ack2: issue_be = ACK_BE_N;
      kind_fetch: issue_be = FETCH_BE_N;
      default: issue_be = rb;
    endcase
  endfunction : issue_be

  function automatic logic is_ack(cbseq_kind_t k);
    is_ack = (k == kind_ack1) || (k == kind_ack2);
  endfunction : is_ack

  // ****************************************
  // timing, vector latch and pin synchronisers
  // ****************************************
  cbseq_if sig_if();
  cbseq_phase u_phase (.clock(clock), .srst(srst), .tick(sig_if.tick));
  cbseq_vector u_vec (.clock(clock), .srst(srst), .vec(sig_if.vec));

  logic ph1_end;
  logic st_end;
  assign ph1_end = sig_if.ph1_end;
  assign st_end = sig_if.st_end;

  logic [19:0] sync1_ff;
  logic [19:0] sync2_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else begin
      sync1_ff <= {cycle_ack_n, next_address_req_n, bus_hold_req, irq_request, data_in};
      sync2_ff <= sync1_ff;
    end
  end

  logic ack_s;
  logic na_s;
  logic hold_s;
  logic irq_s;
  logic [15:0] din_s;
  assign ack_s = ~sync2_ff[19];
  assign na_s = ~sync2_ff[18];
  assign hold_s = sync2_ff[17];
  assign irq_s = sync2_ff[16];
  assign din_s = sync2_ff[15:0];

  // ****************************************
  // sequencer state
  // ****************************************
  cbseq_state_t state_ff;
  cbseq_state_t nxt_state;
  cbseq_kind_t cur_kind_ff;
  cbseq_kind_t q_kind_ff;
  cbseq_kind_t nxt_kind;
  cbseq_ia_t ia_step_ff;
  logic ia_issued_ff;
  logic [2:0] gap_cnt_ff;
  logic na_hit_ff;
  logic [22:0] pf_ptr_ff;
  logic [15:0] q_wdata_ff;
  logic [22:0] addr_ff;
  logic [1:0] be_n_ff;
  logic ads_n_ff;
  logic wr_ff;
  logic intack_ff;
  logic lock_n_ff;
  logic grant_ff;
  logic [15:0] dout_ff;
  logic oe_ff;
  logic taken_ff;
  logic done_ff;
  logic [15:0] rd_ff;

  logic in_data;
  logic ack_end;
  logic gap_done;
  logic ia_need;
  logic pend;
  logic early_ok;
  logic issue;
  logic pipe_issue;

  assign in_data = (state_ff == state_data) || (state_ff == state_data_pipe) ||
                   (state_ff == state_data_idle_next);
  // ack looked at only at the end of data states
  assign ack_end = st_end && ack_s && in_data;
  assign gap_done = (ia_step_ff == ia_gap) && (state_ff == state_idle) &&
                    (gap_cnt_ff == ACK_GAP_STATES - 3'h1);
  assign ia_need = (((ia_step_ff == ia_first) || (ia_step_ff == ia_second)) &&
                    !ia_issued_ff) || gap_done;
  // an idle queue keeps a fetch pending
  assign pend = ia_need || ((ia_step_ff == ia_none) && (req_valid || !queue_full));
  // one cycle ahead at most, never for ack cycles or under hold
  assign early_ok = pend && (ia_step_ff == ia_none) && !hold_s;

  always_comb begin
    nxt_kind = req_valid ? (req_write ? kind_write : kind_read) : kind_fetch;
    if (ia_step_ff == ia_first) begin
      nxt_kind = kind_ack1;
    end else if (ia_step_ff != ia_none) begin
      nxt_kind = kind_ack2;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    if (st_end) begin
      unique case (state_ff)
        state_idle, state_hold_ack: begin
          // new work always starts non-pipelined
          if (hold_s && lock_n_ff) begin
            nxt_state = state_hold_ack;
          end else if (pend) begin
            nxt_state = state_addr;
          end else begin
            nxt_state = state_idle;
          end
        end
        state_addr: nxt_state = state_data;
        state_addr_pipe: begin
          // first state of a pipelined cycle
          if (na_hit_ff) begin
            nxt_state = early_ok ? state_data_pipe : state_data_idle_next;
          end else begin
            nxt_state = state_data;
          end
        end
        state_data, state_data_idle_next: begin
          if (ack_s) begin
            // hold only when unlocked, else next or idle
            if (hold_s && lock_n_ff) begin
              nxt_state = state_hold_ack;
            end else if (pend) begin
              nxt_state = state_addr;
            end else begin
              nxt_state = state_idle;
            end
          end else if (na_hit_ff) begin
            nxt_state = early_ok ? state_data_pipe : state_data_idle_next;
          end else begin
            nxt_state = state_data;
          end
        end
        state_data_pipe: begin
          nxt_state = ack_s ? state_addr_pipe : state_data_pipe;
        end
        default: nxt_state = state_idle;
      endcase
    end
  end

  assign pipe_issue = st_end && (nxt_state == state_data_pipe) && (state_ff != state_data_pipe);
  assign issue = (st_end && (nxt_state == state_addr)) || pipe_issue;

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= state_idle;
      grant_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      grant_ff <= (nxt_state == state_hold_ack);
    end
  end

  // first active sample sticks until the cycle moves on
  always_ff @(posedge clock) begin
    if (srst) begin
      na_hit_ff <= 1'b0;
    end else if (ack_end || issue) begin
      na_hit_ff <= 1'b0;
    end else if (ph1_end && na_s && ((state_ff == state_data) ||
                 (state_ff == state_addr_pipe) || (state_ff == state_data_idle_next))) begin
      na_hit_ff <= 1'b1;
    end
  end

  // ****************************************
  // address, strobe and cycle definition
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      ads_n_ff <= 1'b1;
      addr_ff <= FETCH_RST_ADDR;
      be_n_ff <= 2'h3;
      wr_ff <= 1'b0;
      intack_ff <= 1'b0;
    end else if (issue) begin
      // strobe marks every new address, held one bus state
      ads_n_ff <= 1'b0;
      addr_ff <= issue_addr(nxt_kind, req_addr, pf_ptr_ff);
      be_n_ff <= issue_be(nxt_kind, req_be_n);
      wr_ff <= (nxt_kind == kind_write);
      intack_ff <= is_ack(nxt_kind);
    end else if (st_end) begin
      ads_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur_kind_ff <= kind_fetch;
      q_kind_ff <= kind_fetch;
      q_wdata_ff <= 16'h0000;
      pf_ptr_ff <= FETCH_RST_ADDR;
    end else begin
      if (ack_end && (state_ff == state_data_pipe)) begin
        cur_kind_ff <= q_kind_ff;
      end
      if (pipe_issue) begin
        q_kind_ff <= nxt_kind;
        q_wdata_ff <= req_wdata;
      end else if (issue) begin
        cur_kind_ff <= nxt_kind;
      end
      if (issue && (nxt_kind == kind_fetch)) begin
        pf_ptr_ff <= pf_ptr_ff + 23'h000001;
      end
    end
  end

  // ****************************************
  // data bus, results and lock
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      dout_ff <= 16'h0000;
      oe_ff <= 1'b0;
    end else begin
      if (ack_end) begin
        oe_ff <= (state_ff == state_data_pipe) && (q_kind_ff == kind_write);
        dout_ff <= q_wdata_ff;
      end
      // ack cycles never drive the data bus
      if (issue && !pipe_issue) begin
        oe_ff <= (nxt_kind == kind_write);
        dout_ff <= req_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      taken_ff <= 1'b0;
      done_ff <= 1'b0;
      rd_ff <= 16'h0000;
    end else begin
      taken_ff <= issue && ((nxt_kind == kind_read) || (nxt_kind == kind_write));
      done_ff <= ack_end && !is_ack(cur_kind_ff);
      if (ack_end && !is_ack(cur_kind_ff) && (cur_kind_ff != kind_write)) begin
        rd_ff <= din_s;
      end
    end
  end

  assign sig_if.capture = ack_end && (cur_kind_ff == kind_ack2);
  assign sig_if.low_byte = din_s[7:0];

  // two locked ack cycles with four idle states between
  always_ff @(posedge clock) begin
    if (srst) begin
      ia_step_ff <= ia_none;
      ia_issued_ff <= 1'b0;
      gap_cnt_ff <= 3'h0;
    end else begin
      unique case (ia_step_ff)
        ia_none: begin
          ia_issued_ff <= 1'b0;
          if (irq_s && int_enable) begin
            ia_step_ff <= ia_first;
          end
        end
        ia_first: begin
          if (issue && (nxt_kind == kind_ack1)) begin
            ia_issued_ff <= 1'b1;
          end
          if (ack_end && (cur_kind_ff == kind_ack1)) begin
            ia_step_ff <= ia_gap;
            gap_cnt_ff <= 3'h0;
          end
        end
        ia_gap: begin
          if (gap_done && st_end) begin
            ia_step_ff <= ia_second;
            ia_issued_ff <= 1'b1;
          end else if (st_end && (state_ff == state_idle)) begin
            gap_cnt_ff <= gap_cnt_ff + 3'h1;
          end
        end
        ia_second: begin
          if (ack_end && (cur_kind_ff == kind_ack2)) begin
            ia_step_ff <= ia_none;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lock_n_ff <= 1'b1;
    end else if (issue && (nxt_kind == kind_ack1)) begin
      lock_n_ff <= 1'b0;
    end else if (ack_end && (cur_kind_ff == kind_ack2)) begin
      lock_n_ff <= 1'b1;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign address_strobe_n = ads_n_ff;
  assign address_hi = addr_ff[22:2];
  assign addr_bit2 = addr_ff[1];
  assign addr_bit1 = addr_ff[0];
  assign high_byte_en_n = be_n_ff[1];
  assign low_byte_en_n = be_n_ff[0];
  assign write_read = wr_ff;
  assign int_ack_cycle = intack_ff;
  assign bus_lock_n = lock_n_ff;
  assign bus_hold_grant = grant_ff;
  assign data_out = dout_ff;
  assign data_oe = oe_ff;
  assign req_taken = taken_ff;
  assign cycle_done = done_ff;
  assign rd_data = rd_ff;
  assign irq_vector = sig_if.vector;
  assign vector_valid = sig_if.vector_valid;
  assign bus_state = state_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_addr_to_data: assert property (
    (state_ff == state_addr) && st_end |=> (state_ff == state_data))
    else $error("address state not followed by data state");
  chk_wait_repeat: assert property (
    (state_ff == state_data) && st_end && !ack_s && !na_hit_ff |=> (state_ff == state_data))
    else $error("wait state not repeated");
  chk_idle_no_work: assert property (
    (state_ff == state_data) && ack_end && !hold_s && !pend |=> (state_ff == state_idle))
    else $error("idle not entered after ack");
  chk_strobe_issue: assert property (
    issue |=> !address_strobe_n ##1 !address_strobe_n ##1 address_strobe_n || $past(issue))
    else $error("strobe not one bus state");
  chk_addr_stable: assert property (
    $fell(address_strobe_n) |-> ##1 $stable(addr_ff)[*3])
    else $error("address changed too soon");
  chk_pipe_start: assert property (
    (state_ff == state_data_pipe) && ack_end |=> (state_ff == state_addr_pipe))
    else $error("pipelined cycle did not start");
  chk_gap_idle: assert property (
    (ia_step_ff == ia_gap) && st_end && !gap_done |=> (state_ff == state_idle))
    else $error("bus left idle inside ack gap");
  chk_lock_gap: assert property (
    (ia_step_ff == ia_gap) || (ia_step_ff == ia_second) |-> !bus_lock_n)
    else $error("lock dropped between ack cycles");
  chk_hold_unlocked: assert property (
    (state_ff == state_hold_ack) |-> bus_lock_n)
    else $error("hold granted while locked");
  chk_ack_float: assert property (
    int_ack_cycle && in_data |-> !data_oe)
    else $error("data driven in ack cycle");

  cov_pipelined: cover property ((state_ff == state_addr_pipe) ##2 (state_ff == state_data_pipe));
  cov_idle_next: cover property (state_ff == state_data_idle_next);
  cov_vector: cover property (vector_valid);
  cov_hold: cover property (bus_hold_grant);
endmodule : cbseq_top
`default_nettype wire

// ### cbseq_glue.sv
`timescale 1ns/10ps
`default_nettype none
module cbseq_glue import cbseq_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // behaviour chosen by the bench
  input wire logic [3:0] ack_delay,
  input wire logic na_on,
  input wire logic [7:0] vec,
  // bus seen from the sequencer
  input wire logic [2:0] bus_state,
  input wire logic [20:0] address_hi,
  input wire logic addr_bit2,
  input wire logic int_ack_cycle,
  input wire logic write_read,
  // answers
  output logic cycle_ack_n,
  output logic next_address_req_n,
  output logic [15:0] data_in,
  output logic cycle_end
);
  // ****************************************
  // cycle tracking and acknowledge
  // ****************************************
  logic [2:0] prev_ff;
  logic [3:0] wait_ff;
  logic [15:0] noise_ff;
  logic in_data;
  function automatic logic is_data(input logic [2:0] s);
    return s == state_data || s == state_data_pipe || s == state_data_idle_next;
  endfunction : is_data
  assign in_data = is_data(bus_state);
  // only an acknowledged cycle leaves the data states
  assign cycle_end = is_data(prev_ff) && !in_data;
  always_ff @(posedge clock) begin
    if (srst) begin
      prev_ff <= state_idle;
      wait_ff <= 4'h0;
    end else begin
      prev_ff <= bus_state;
      if (cycle_end) begin
        wait_ff <= 4'h0;
      end else if (in_data && wait_ff != 4'hf) begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
  // a zero delay keeps the pin low: the sequencer ends each data state itself
  assign cycle_ack_n = !(wait_ff >= ack_delay);
  assign next_address_req_n = !na_on;
  // ****************************************
  // data bus
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      noise_ff <= 16'h0;
    end else begin
      noise_ff <= noise_ff + 16'h1357;
    end
  end
  // an undriven bus shows a moving pattern, never the last word
  always_comb begin
    data_in = noise_ff;
    if (int_ack_cycle && !addr_bit2) begin
      data_in[7:0] = vec;
    end else if (!int_ack_cycle && !write_read && in_data) begin
      data_in = {address_hi[7:0], ~address_hi[7:0]};
    end
  end
endmodule : cbseq_glue
`default_nettype wire

// ### cpu_bus_cycle_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_cycle_sequencer_tb import cbseq_pkg::*;;
  // ****************************************
  // stimulus, partner and monitor
  // ****************************************
  localparam logic [7:0] VEC = 8'ha5;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic bus_hold_req = 1'b0, irq_request = 1'b0, int_enable = 1'b0, req_valid = 1'b0;
  logic req_write = 1'b0, queue_full = 1'b1, na_on = 1'b0;
  logic [22:0] req_addr = 23'h0512a6;
  logic [1:0] req_be_n = 2'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [3:0] ack_delay = 4'h0;
  logic cycle_ack_n, next_address_req_n, cycle_end, strobe_q;
  logic [15:0] data_in, data_out, rd_data;
  logic [20:0] address_hi;
  logic address_strobe_n, addr_bit2, addr_bit1, high_byte_en_n, low_byte_en_n, write_read;
  logic int_ack_cycle, bus_lock_n, bus_hold_grant, data_oe, req_taken, cycle_done;
  logic vector_valid;
  logic [7:0] irq_vector;
  logic [2:0] bus_state;
  int num_errors = 0;
  int tests_run = 0;
  int data_clks = 0;
  int gap_clks = 0;
  int outstanding = 0;
  always #20 clock = ~clock;
  cbseq_top uut (.clock(clock), .srst(srst), .cycle_ack_n(cycle_ack_n),
    .next_address_req_n(next_address_req_n), .bus_hold_req(bus_hold_req),
    .irq_request(irq_request), .data_in(data_in), .int_enable(int_enable),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_be_n(req_be_n),
    .req_wdata(req_wdata), .queue_full(queue_full), .address_strobe_n(address_strobe_n),
    .address_hi(address_hi), .addr_bit2(addr_bit2), .addr_bit1(addr_bit1),
    .high_byte_en_n(high_byte_en_n), .low_byte_en_n(low_byte_en_n), .write_read(write_read),
    .int_ack_cycle(int_ack_cycle), .bus_lock_n(bus_lock_n), .bus_hold_grant(bus_hold_grant),
    .data_out(data_out), .data_oe(data_oe), .req_taken(req_taken), .cycle_done(cycle_done),
    .rd_data(rd_data), .irq_vector(irq_vector), .vector_valid(vector_valid),
    .bus_state(bus_state));
  cbseq_glue partner (.clock(clock), .srst(srst), .ack_delay(ack_delay), .na_on(na_on),
    .vec(VEC), .bus_state(bus_state), .address_hi(address_hi), .addr_bit2(addr_bit2),
    .int_ack_cycle(int_ack_cycle), .write_read(write_read), .cycle_ack_n(cycle_ack_n),
    .next_address_req_n(next_address_req_n), .data_in(data_in), .cycle_end(cycle_end));
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    tests_run++;
    if (seen !== expected) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  always @(posedge clock) begin
    strobe_q <= address_strobe_n;
    if (srst) begin
      gap_clks = 100;
      outstanding = 0;
    end else begin
      gap_clks++;
      if (bus_state === state_data) data_clks++;
      if (cycle_end === 1'b1) outstanding--;
      if (strobe_q === 1'b1 && address_strobe_n === 1'b0) begin
        check(gap_clks >= ADDR_STABLE_CLKS, 1'b1);
        gap_clks = 0;
        outstanding++;
        check(outstanding <= 2, 1'b1);
      end
      if (bus_lock_n === 1'b0) check(bus_hold_grant, 1'b0);
    end
  end
  // ****************************************
  // waits and scenarios
  // ****************************************
  function automatic logic hit(input int sel, input logic [2:0] st);
    case (sel)
      0: return req_taken === 1'b1;
      1: return cycle_done === 1'b1;
      2: return vector_valid === 1'b1;
      3: return bus_hold_grant === 1'b1;
      4: return address_strobe_n === 1'b0;
      default: return bus_state === st;
    endcase
  endfunction : hit
  task automatic wait_on(input int sel, input logic [2:0] st);
    int n;
    n = 0;
    while (!hit(sel, st) && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      $display("wrong value at %0t: wait %h gave up, state %h", $time, sel, st);
      conclude();
    end
  endtask : wait_on
  task automatic test_reset;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check({address_strobe_n, bus_lock_n, bus_hold_grant, data_oe, bus_state}, 7'h60);
  endtask : test_reset
  task automatic test_read;
    @(posedge clock);
    ack_delay <= 4'h8;
    req_valid <= 1'b1;
    wait_on(0, state_idle);
    check({address_strobe_n, bus_state}, {1'b0, state_addr});
    check({address_hi, addr_bit2, addr_bit1}, 23'h0512a6);
    data_clks = 0;
    @(posedge clock);
    req_valid <= 1'b0;
    wait_on(1, state_idle);
    check(data_clks >= 4, 1'b1);
    check(data_clks % BUS_STATE_CLKS, 0);
    check(rd_data, 16'ha956);
  endtask : test_read
  task automatic test_write;
    @(posedge clock);
    ack_delay <= 4'h4;
    req_write <= 1'b1;
    req_be_n <= 2'h1;
    req_wdata <= 16'hc3e1;
    req_valid <= 1'b1;
    wait_on(0, state_idle);
    @(posedge clock);
    req_valid <= 1'b0;
    wait_on(-1, state_data);
    check({data_oe, write_read, high_byte_en_n, low_byte_en_n, data_out}, 20'hdc3e1);
    wait_on(1, state_idle);
    @(posedge clock);
    req_write <= 1'b0;
    req_be_n <= 2'h0;
  endtask : test_write
  task automatic test_idle_next;
    @(posedge clock);
    na_on <= 1'b1;
    ack_delay <= 4'hc;
    req_valid <= 1'b1;
    wait_on(0, state_idle);
    @(posedge clock);
    req_valid <= 1'b0;
    wait_on(-1, state_data_idle_next);
    check(address_strobe_n, 1'b1);
    @(posedge clock);
    req_addr <= 23'h000044;
    req_valid <= 1'b1;
    wait_on(0, state_idle);
    // the strobe, not the request pin, says the next address is out
    check({address_strobe_n, bus_state}, {1'b0, state_data_pipe});
    check({address_hi, addr_bit2, addr_bit1}, 23'h000044);
    @(posedge clock);
    req_valid <= 1'b0;
    na_on <= 1'b0;
    wait_on(-1, state_addr_pipe);
    wait_on(-1, state_idle);
  endtask : test_idle_next
  task automatic test_pipe;
    @(posedge clock);
    na_on <= 1'b1;
    // one wait state: a zero-wait cycle is acked before pipelining can start
    ack_delay <= 4'h1;
    queue_full <= 1'b0;
    wait_on(-1, state_addr_pipe);
    repeat (2) @(posedge clock);
    #1;
    check(bus_state, state_data_pipe);
    @(posedge clock);
    queue_full <= 1'b1;
    na_on <= 1'b0;
    wait_on(-1, state_idle);
  endtask : test_pipe
  task automatic test_irq;
    int n;
    @(posedge clock);
    ack_delay <= 4'h3;
    int_enable <= 1'b1;
    irq_request <= 1'b1;
    wait_on(4, state_idle);
    check(int_ack_cycle, 1'b1);
    check({bus_lock_n, addr_bit2, high_byte_en_n, low_byte_en_n, address_hi}, {4'h6, 21'h0});
    // hold only after the lock is out, so it must wait for the whole pair
    @(posedge clock);
    irq_request <= 1'b0;
    bus_hold_req <= 1'b1;
    wait_on(-1, state_idle);
    n = 0;
    while (bus_state === state_idle && n < 20) begin
      check({bus_lock_n, data_oe}, 2'h0);
      @(posedge clock);
      #1;
      n++;
    end
    check(n, 8);
    check({int_ack_cycle, bus_lock_n, addr_bit2, high_byte_en_n, low_byte_en_n, address_hi}, {5'h12, 21'h0});
    wait_on(2, state_idle);
    check({bus_lock_n, irq_vector}, {1'b1, VEC});
    wait_on(3, state_idle);
    check(bus_state, state_hold_ack);
    @(posedge clock);
    bus_hold_req <= 1'b0;
    int_enable <= 1'b0;
    wait_on(-1, state_idle);
  endtask : test_irq
  initial begin
    test_reset();
    test_read();
    test_write();
    test_idle_next();
    test_pipe();
    test_irq();
    conclude();
  end
endmodule : cpu_bus_cycle_sequencer_tb
`default_nettype wire
